// >>> verilog/ldsq_pkg.sv
// Constants, register map and state types for the channel C dimming sequencer.
// Functional notes
// - Reserved bits read zero and ignore writes in every control register.
// - Power-on reset returns every register of the block to its default.
// - Channel B on-duration field bits 4-0 times 64 ms, codes 0 to 31.
// - Channel C sink current comes from 4-bit field bits 3-0, reset zero.
// - First phase lasts 7-bit field times 64 ms; zero gives nothing.
// - Second phase lasts its 7-bit field times 64 ms.
// - Third phase lasts its 7-bit field times 64 ms.
// - Fourth phase lasts its 7-bit field times 64 ms.
// - Period phase lasts its 7-bit field times 64 ms, at most 127 units.
// - On-signal PWM over 8 ms, high for duty plus one thirty-seconds.
// - Maximum duty code keeps the on-signal high all period.
// - Current is 2 mA per code step from 2 mA, saturating at 20 mA.
// - With ramp enabled current rises over shared rise field times 8 ms.
// - Channel works only when enabled; sequencer runs only when its bit is set.
package ldsq_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_B_ON = 8'h56;
  localparam logic [7:0] IDX_C_CUR = 8'h57;
  localparam logic [7:0] IDX_C_PH1 = 8'h58;
  localparam logic [7:0] IDX_C_PH2 = 8'h59;
  localparam logic [7:0] IDX_C_PH3 = 8'h5A;
  localparam logic [7:0] IDX_C_PH4 = 8'h5B;
  localparam logic [7:0] IDX_C_PER = 8'h5C;
  localparam logic [7:0] IDX_C_DUTY = 8'h5D;
  localparam logic [7:0] IDX_RISE = 8'h5F;
  localparam logic [7:0] IDX_ENABLE = 8'h61;
  localparam logic [7:0] IDX_STATUS = 8'h70;

  // Storage slots; the status slot is read-only and has no storage.
  localparam int REG_CNT = 11;
  localparam logic [3:0] S_CUR = 4'h0;
  localparam logic [3:0] S_PH1 = 4'h1;
  localparam logic [3:0] S_PER = 4'h5;
  localparam logic [3:0] S_DUTY = 4'h6;
  localparam logic [3:0] S_BON = 4'h7;
  localparam logic [3:0] S_RISE = 4'h8;
  localparam logic [3:0] S_EN = 4'h9;
  localparam logic [3:0] S_STAT = 4'hA;
  localparam logic [3:0] S_NONE = 4'hF;
  localparam logic [7:0] REG_IDX [REG_CNT] = '{IDX_C_CUR, IDX_C_PH1, IDX_C_PH2, IDX_C_PH3,
    IDX_C_PH4, IDX_C_PER, IDX_C_DUTY, IDX_B_ON, IDX_RISE, IDX_ENABLE, IDX_STATUS};
  localparam logic [7:0] REG_MASK [REG_CNT] = '{8'h2F, 8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h7F,
    8'h1F, 8'h1F, 8'h1F, 8'h77, 8'h00};
  localparam logic [7:0] REG_RST = 8'h00;

  // Field positions.
  localparam int CUR_MSB = 3;
  localparam int RAMP_EN_BIT = 5;
  localparam int EN_B_ON_BIT = 5;
  localparam int EN_C_ON_BIT = 4;
  localparam int EN_C_SEQ_BIT = 0;

  // Current map.
  localparam logic [3:0] CUR_SAT_CODE = 4'h9;
  localparam logic [4:0] CUR_MA_BASE = 5'h02;
  localparam logic [4:0] CUR_MA_MAX = 5'h14;

  // Timing: everything counts 250 us slots.
  localparam int CLK_MHZ = 250;
  localparam int T_SLOT_US = 250;
  localparam int T_UNIT_US = 64000;
  localparam int T_RISE_US = 8000;
  localparam int T_PWM_US = 8000;
  localparam int SLOT_CYCLES_DEF = T_SLOT_US * CLK_MHZ;
  localparam int UNIT_SLOTS = T_UNIT_US / T_SLOT_US;
  localparam int PWM_SLOTS = T_PWM_US / T_SLOT_US;
  localparam logic [5:0] RAMP_FULL = 6'(T_RISE_US / T_SLOT_US);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [5:0] {
    PH_IDLE = 6'h01,
    PH_1 = 6'h02,
    PH_2 = 6'h04,
    PH_3 = 6'h08,
    PH_4 = 6'h10,
    PH_PER = 6'h20
  } ldsq_phase_e;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } ldsq_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ldsq_axil_rsp_s;

  typedef struct packed {
    logic [REG_CNT-2:0][7:0] regs;
    logic aw_got;
    logic [3:0] aw_slot;
    logic w_got;
    logic [7:0] w_byte;
    logic w_lane;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [31:0] slot_cnt;
    logic [4:0] pwm_pos;
    ldsq_phase_e phase;
    logic [14:0] ph_slots;
    logic lit;
    logic [4:0] ramp_div;
    logic [5:0] ramp_lvl;
    logic on_sig;
    logic [4:0] sink_ma;
    logic b_run;
    logic [12:0] b_slots;
    logic b_on;
  } ldsq_state_s;

endpackage

// >>> verilog/ldsq_top.sv
// Channel C dimming sequencer with its register file on an AXI4-Lite slave.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ldsq_top #(
  parameter int SLOT_CYCLES = ldsq_pkg::SLOT_CYCLES_DEF
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire ldsq_pkg::ldsq_axil_req_s bus_req_i,
  output ldsq_pkg::ldsq_axil_rsp_s bus_rsp_o,
  output logic chan_c_on_signal_o,
  output logic [4:0] chan_c_sink_ma_o,
  output logic [5:0] chan_c_ramp_level_o,
  output logic chan_b_on_duration_o
);
  import ldsq_pkg::*;

  ldsq_state_s q;
  ldsq_state_s d;

  function automatic logic [3:0] slot_of(input logic [31:0] addr);
    slot_of = S_NONE;
    for (int i = 0; i < REG_CNT; i++) begin
      if (addr == {22'h000000, REG_IDX[i], 2'h0}) begin
        slot_of = 4'(i);
      end
    end
  endfunction

  logic tick;
  logic chan_on;
  logic seq_on;
  logic lit;
  logic phase_done;
  logic [6:0] ph_len;
  logic [14:0] ph_target;
  logic [12:0] b_target;
  logic [3:0] cur_code;
  logic [4:0] rise;
  logic [3:0] rd_slot;
  logic [7:0] status;
  ldsq_phase_e ph_next;

  always_comb begin
    d = q;
    tick = (q.slot_cnt == 32'(SLOT_CYCLES - 1));
    chan_on = q.regs[S_EN][EN_C_ON_BIT];
    seq_on = q.regs[S_EN][EN_C_SEQ_BIT];
    cur_code = q.regs[S_CUR][CUR_MSB:0];
    rise = q.regs[S_RISE][4:0];
    status = {q.lit, q.ramp_lvl == RAMP_FULL, q.b_on, q.phase[5:1]};

    // Free-running slot timebase; the PWM position walks one slot at a time.
    d.slot_cnt = tick ? 32'h00000000 : q.slot_cnt + 32'h00000001;
    if (tick) begin
      d.pwm_pos = 5'(q.pwm_pos + 5'(1) == 5'(PWM_SLOTS) ? 0 : q.pwm_pos + 5'(1));
    end

    // Phase sequencer.
    case (q.phase)
      PH_1: begin
        ph_len = q.regs[S_PH1][6:0];
        ph_next = PH_2;
      end
      PH_2: begin
        ph_len = q.regs[S_PH1 + 4'h1][6:0];
        ph_next = PH_3;
      end
      PH_3: begin
        ph_len = q.regs[S_PH1 + 4'h2][6:0];
        ph_next = PH_4;
      end
      PH_4: begin
        ph_len = q.regs[S_PH1 + 4'h3][6:0];
        ph_next = PH_PER;
      end
      PH_PER: begin
        ph_len = q.regs[S_PER][6:0];
        ph_next = PH_1;
      end
      default: begin
        ph_len = 7'h00;
        ph_next = PH_1;
      end
    endcase
    ph_target = 15'(32'(ph_len) * UNIT_SLOTS);
    // A zero-length phase holds for a single clock only, so it is in effect skipped.
    phase_done = (q.phase == PH_IDLE) || (ph_target == 15'h0000) ||
      (tick && (q.ph_slots + 15'h0001 == ph_target));
    if (!chan_on || !seq_on) begin
      d.phase = PH_IDLE;
      d.ph_slots = 15'h0000;
    end else if (phase_done) begin
      d.phase = ph_next;
      d.ph_slots = 15'h0000;
    end else if (tick) begin
      d.ph_slots = q.ph_slots + 15'h0001;
    end

    // Without the sequencer the channel stays lit; with it, phases 1 and 3 are lit.
    lit = chan_on && (!seq_on || q.phase == PH_1 || q.phase == PH_3);
    d.lit = lit;

    // Ramp: 32 steps, each lasting the rise field in slots, so the total is rise x 8 ms.
    if (!lit) begin
      d.ramp_lvl = 6'h00;
      d.ramp_div = 5'h00;
    end else if (!q.lit) begin
      d.ramp_lvl = q.regs[S_CUR][RAMP_EN_BIT] ? 6'h00 : RAMP_FULL;
      d.ramp_div = 5'h00;
    end else if (tick && q.ramp_lvl != RAMP_FULL) begin
      if (rise == 5'h00 || q.ramp_div + 5'h01 >= rise) begin
        d.ramp_lvl = q.ramp_lvl + 6'h01;
        d.ramp_div = 5'h00;
      end else begin
        d.ramp_div = q.ramp_div + 5'h01;
      end
    end
    if (q.regs[S_CUR][RAMP_EN_BIT] && q.lit && rise == 5'h00) begin
      d.ramp_lvl = RAMP_FULL;
    end

    // Duty code 31 compares true at every position, so the output never drops.
    d.on_sig = lit && (q.pwm_pos <= q.regs[S_DUTY][4:0]);
    if (!lit) begin
      d.sink_ma = 5'h00;
    end else if (cur_code > CUR_SAT_CODE) begin
      d.sink_ma = CUR_MA_MAX;
    end else begin
      d.sink_ma = 5'({cur_code, 1'b0}) + CUR_MA_BASE;
    end

    // Channel B on-window, restarted by each write of its on-duration register.
    b_target = 13'(32'(q.regs[S_BON][4:0]) * UNIT_SLOTS);
    if (q.b_run && (b_target == 13'h0000 ||
        (tick && q.b_slots + 13'h0001 >= b_target))) begin
      d.b_run = 1'b0;
    end else if (q.b_run && tick) begin
      d.b_slots = q.b_slots + 13'h0001;
    end
    d.b_on = q.b_run && q.regs[S_EN][EN_B_ON_BIT] && b_target != 13'h0000;

    // AXI4-Lite write path: address and data may arrive in either order.
    if (bus_req_i.awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.aw_slot = slot_of(bus_req_i.awaddr);
    end
    if (bus_req_i.wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.w_byte = bus_req_i.wdata[7:0];
      d.w_lane = bus_req_i.wstrb[0];
    end
    if (q.bvalid && bus_req_i.bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (q.aw_slot == S_NONE) ? RESP_DECERR : RESP_OKAY;
      if (q.w_lane && q.aw_slot < S_STAT) begin
        d.regs[q.aw_slot] = q.w_byte & REG_MASK[q.aw_slot];
        if (q.aw_slot == S_BON) begin
          d.b_run = 1'b1;
          d.b_slots = 13'h0000;
        end
      end
    end

    // Read path; reserved bits are stored as zero, so they read back as zero.
    rd_slot = slot_of(bus_req_i.araddr);
    if (bus_req_i.arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = (rd_slot == S_NONE) ? RESP_DECERR : RESP_OKAY;
      if (rd_slot == S_STAT) begin
        d.rdata = status;
      end else if (rd_slot < S_STAT) begin
        d.rdata = q.regs[rd_slot];
      end else begin
        d.rdata = 8'h00;
      end
    end else if (q.rvalid && bus_req_i.rready) begin
      d.rvalid = 1'b0;
    end

    // Ready is held low while a transfer waits, which keeps one of each in flight.
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.regs <= {(REG_CNT - 1){REG_RST}};
      q.phase <= PH_IDLE;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign bus_rsp_o = '{awready: q.awready, wready: q.wready, bvalid: q.bvalid,
    bresp: q.bresp, arready: q.arready, rvalid: q.rvalid, rdata: {24'h000000, q.rdata},
    rresp: q.rresp};
  assign chan_c_on_signal_o = q.on_sig;
  assign chan_c_sink_ma_o = q.sink_ma;
  assign chan_c_ramp_level_o = q.ramp_lvl;
  assign chan_b_on_duration_o = q.b_on;

endmodule
`default_nettype wire

// >>> verification/ldsq_assertions.sv
// Port-level properties of the sequencer top, attached by bind.
`timescale 1ns/1ps
`default_nettype none
module ldsq_chk #(
  parameter int SLOT_CYCLES = 4
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire ldsq_pkg::ldsq_axil_req_s bus_req_i,
  input wire ldsq_pkg::ldsq_axil_rsp_s bus_rsp_o,
  input wire logic chan_c_on_signal_o,
  input wire logic [4:0] chan_c_sink_ma_o,
  input wire logic [5:0] chan_c_ramp_level_o,
  input wire logic chan_b_on_duration_o
);
  import ldsq_pkg::*;
  ldsq_axil_req_s q;
  ldsq_axil_rsp_s r;
  assign q = bus_req_i;
  assign r = bus_rsp_o;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  chk_rsvd_zero: assert property (
    r.rvalid |-> r.rdata[31:8] == 24'h0 && (r.rresp == RESP_OKAY || r.rdata == 32'h0))
    else $error("upper read bits set or refused read not zero");
  chk_reset_clear: assert property (
    $rose(nrst_i) |-> r == '0 && chan_c_sink_ma_o == 5'h0 && !chan_b_on_duration_o)
    else $error("outputs not cleared by reset");
  chk_sink_range: assert property (
    chan_c_sink_ma_o != 5'h0 |-> chan_c_sink_ma_o inside {[5'h02:5'h14]} && !chan_c_sink_ma_o[0])
    else $error("sink current off the 2 mA grid");
  chk_ramp_top: assert property (chan_c_ramp_level_o <= 6'h20)
    else $error("ramp level above full");
  chk_dark_off: assert property (chan_c_sink_ma_o == 5'h0 |-> !chan_c_on_signal_o)
    else $error("on-signal high while channel dark");
  chk_read_answer: assert property (q.arvalid && r.arready && ce_i |=> r.rvalid && !r.arready)
    else $error("read answer late");
  // Write answer is counted from the edge that takes both address and data.
  chk_write_answer: assert property (
    q.awvalid && r.awready && q.wvalid && r.wready && ce_i ##1 ce_i |=> r.bvalid)
    else $error("write answer late");
  chk_read_done: assert property (r.rvalid && q.rready && ce_i |=> !r.rvalid)
    else $error("read answer not withdrawn");
  chk_write_done: assert property (r.bvalid && q.bready && ce_i |=> !r.bvalid)
    else $error("write answer not withdrawn");
  chk_hold_freeze: assert property (!ce_i |=> $stable(r) && $stable(chan_b_on_duration_o))
    else $error("state moved with clock enable low");
  cov_read: cover property (q.arvalid && r.arready);
  cov_write: cover property (r.bvalid && q.bready);
  cov_lit: cover property ($rose(chan_c_on_signal_o));
  cov_b_win: cover property ($fell(chan_b_on_duration_o));
endmodule
bind ldsq_top ldsq_chk #(.SLOT_CYCLES(SLOT_CYCLES)) u_ldsq_chk (.clock_i(clock_i),
  .nrst_i(nrst_i), .ce_i(ce_i), .bus_req_i(bus_req_i), .bus_rsp_o(bus_rsp_o),
  .chan_c_on_signal_o(chan_c_on_signal_o), .chan_c_sink_ma_o(chan_c_sink_ma_o),
  .chan_c_ramp_level_o(chan_c_ramp_level_o), .chan_b_on_duration_o(chan_b_on_duration_o));
`default_nettype wire

// >>> verification/led_dimming_sequencer_regs_bench.sv
// Self-checking bench for the channel C dimming sequencer.
`timescale 1ns/1ps
`default_nettype none
module led_dimming_sequencer_regs_bench;
  import ldsq_pkg::*;
  localparam int SC = 4;
  localparam logic [7:0] IX [9] = '{IDX_B_ON, IDX_C_CUR, IDX_C_PH1, IDX_C_PH2, IDX_C_PH3,
    IDX_C_PH4, IDX_C_PER, IDX_C_DUTY, 8'h40};
  localparam logic [7:0] EX [9] = '{8'h1F, 8'h2F, 8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h1F, 8'h0};
  localparam int DT [3] = '{0, 7, 31};
  localparam int CU [3] = '{0, 4, 15};
  localparam logic [4:0] PS [4] = '{5'h01, 5'h02, 5'h10, 5'h01};
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  ldsq_axil_req_s q = '0;
  ldsq_axil_rsp_s r;
  logic on_s, b_on;
  logic [4:0] ma;
  logic [5:0] lvl;
  logic [1:0] rs;
  logic [31:0] v;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int k, h;
  always #2 clock_i = ~clock_i;
  ldsq_top #(.SLOT_CYCLES(SC)) u_ldsq_top (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .bus_req_i(q), .bus_rsp_o(r), .chan_c_on_signal_o(on_s), .chan_c_sink_ma_o(ma),
    .chan_c_ramp_level_o(lvl), .chan_b_on_duration_o(b_on));
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // Both answer readies stay high, so no task ever drops and raises them in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
    q.awaddr <= {22'h0, a, 2'h0};
    q.wdata <= {24'h0, d};
    q.wstrb <= s;
    q.awvalid <= 1'b1;
    q.wvalid <= 1'b1;
    do begin
      @(posedge clock_i);
      if (r.awready) q.awvalid <= 1'b0;
      if (r.wready) q.wvalid <= 1'b0;
    end while (!r.bvalid);
    rs = r.bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    q.araddr <= {22'h0, a, 2'h0};
    q.arvalid <= 1'b1;
    do begin
      @(posedge clock_i);
      if (r.arready) q.arvalid <= 1'b0;
    end while (!r.rvalid);
    v = r.rdata;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    q.bready <= 1'b1;
    q.rready <= 1'b1;
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    for (k = 0; k < 9; k++) begin
      rd(IX[k]);
      chk("reset value", 32'h0, v);
      wr(IX[k], 8'hFF);
      chk("write resp", (k == 8) ? {30'h0, RESP_DECERR} : 32'h0, {30'h0, rs});
      rd(IX[k]);
      chk("read back", {24'h0, EX[k]}, v);
    end
    nrst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    rd(IDX_C_PH4);
    chk("after reset", 32'h0, v);
    // Only byte lane 0 carries the register, so a write without it must leave the value alone.
    wr(IDX_C_PH4, 8'h55, 4'hE);
    rd(IDX_C_PH4);
    chk("lane 0 off", 32'h0, v);
    wr(IDX_ENABLE, 8'h10);
    for (k = 0; k < 3; k++) begin
      wr(IDX_C_CUR, CU[k][7:0]);
      wr(IDX_C_DUTY, DT[k][7:0]);
      repeat (8) @(posedge clock_i);
      chk("sink mA", ((CU[k] > 9) ? 9 : CU[k]) * 2 + 2, {27'h0, ma});
      h = 0;
      repeat (32 * SC) begin
        @(posedge clock_i);
        h += (on_s === 1'b1);
      end
      chk("high cycles", (DT[k] + 1) * SC, h);
    end
    wr(IDX_ENABLE, 8'h00);
    repeat (4) @(posedge clock_i);
    chk("disabled", 32'h0, {26'h0, on_s, ma});
    wr(IDX_RISE, 8'h01);
    wr(IDX_C_CUR, 8'h29);
    wr(IDX_ENABLE, 8'h10);
    repeat (2) @(posedge clock_i);
    chk("ramp start", 32'h1, {31'h0, lvl < 6'h20});
    repeat (40 * SC) @(posedge clock_i);
    chk("ramp full", 32'h20, {26'h0, lvl});
    wr(IDX_C_PH1, 8'h01);
    wr(IDX_C_PH2, 8'h01);
    wr(IDX_C_PER, 8'h01);
    wr(IDX_ENABLE, 8'h11);
    repeat (500) @(posedge clock_i);
    for (k = 0; k < 4; k++) begin
      rd(IDX_STATUS);
      chk("phase", {26'h0, PS[k] == 5'h01, PS[k]}, {26'h0, v[7], v[4:0]});
      repeat (1010) @(posedge clock_i);
    end
    wr(IDX_ENABLE, 8'h20);
    wr(IDX_B_ON, 8'h01);
    repeat (8) @(posedge clock_i);
    chk("b window", 32'h1, {31'h0, b_on});
    repeat (500) @(posedge clock_i);
    ce_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    ce_i <= 1'b1;
    // The frozen cycles push the window's end past the point where it would end unfrozen.
    repeat (501) @(posedge clock_i);
    chk("b window held", 32'h1, {31'h0, b_on});
    repeat (99) @(posedge clock_i);
    chk("b window end", 32'h0, {31'h0, b_on});
    end_sim();
  end
endmodule
`default_nettype wire
